// ==== plr_axil_wr.v ====
// Write address and write data capture for the AXI4-Lite slave.
// Assumes the parent consumes both halves with a one-cycle take pulse.
`timescale 1ns/1ns
`include "plr_defs.vh"

module plr_axil_wr (
    // Clock and reset
    input  wire                   aclk,
    input  wire                   aresetn,
    // Write address channel
    input  wire [`PLR_ADDR_W-1:0] awaddr,
    input  wire                   awvalid,
    output reg                    awready,
    // Write data channel
    input  wire [31:0]            wdata,
    input  wire [3:0]             wstrb,
    input  wire                   wvalid,
    output reg                    wready,
    // Held request towards the register file
    input  wire                   take,
    output reg  [`PLR_ADDR_W-1:0] held_addr,
    output reg  [31:0]            held_data,
    output reg  [3:0]             held_strb,
    output wire                   both_held
);

    reg  aw_full;
    reg  w_full;
    wire next_aw_full;
    wire next_w_full;

    // Each half is held alone, so address and data may come in any order
    assign next_aw_full = take ? 1'b0 : (aw_full | (awvalid & awready));
    assign next_w_full  = take ? 1'b0 : (w_full | (wvalid & wready));
    assign both_held    = aw_full & w_full;

    // Ready drops while a half is parked, which stalls the master
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            awready   <= 1'b0;
            wready    <= 1'b0;
            held_addr <= {`PLR_ADDR_W{1'b0}};
            held_data <= 32'h00000000;
            held_strb <= 4'h0;
        end else begin
            aw_full <= next_aw_full;
            w_full  <= next_w_full;
            awready <= ~next_aw_full;
            wready  <= ~next_w_full;
            if (awvalid && awready) begin
                held_addr <= awaddr;
            end
            if (wvalid && wready) begin
                held_data <= wdata;
                held_strb <= wstrb;
            end
        end
    end

endmodule

// ==== plr_defs.vh ====
// Constants for the synthesizer pump and enable register bank.
// Assumes an AXI4-Lite slave with 32-bit data and 12-bit byte addresses.
`ifndef PLR_DEFS_VH
`define PLR_DEFS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PLR_ADDR_W        12
`define PLR_IDX_PUMP      10'h058
`define PLR_IDX_ENABLE    10'h059
`define PLR_IDX_REFDIV    10'h060
`define PLR_IDX_STATUS    10'h061

// ----------------------------------------------------------------------
// Pump bias control fields
// ----------------------------------------------------------------------
`define PLR_PUMP_CODE_LSB 0
`define PLR_PUMP_CODE_MSB 3
`define PLR_PUMP_SRC_BIT  4
`define PLR_PUMP_FCB_LSB  5
`define PLR_PUMP_FCB_MSB  7
`define PLR_PUMP_RESET    8'h12

// ----------------------------------------------------------------------
// Enable control fields
// ----------------------------------------------------------------------
`define PLR_EN_FCB0_BIT   0
`define PLR_EN_SYNTH_BIT  1
`define PLR_EN_FCB21_LSB  2
`define PLR_EN_FCB21_MSB  3
`define PLR_EN_REFDIV_BIT 4
`define PLR_EN_FCB43_LSB  5
`define PLR_EN_FCB43_MSB  6
`define PLR_EN_UNUSED_BIT 7
`define PLR_EN_WMASK      8'h7F
`define PLR_ENABLE_RESET  8'h41

// ----------------------------------------------------------------------
// Reference divider value and responses
// ----------------------------------------------------------------------
`define PLR_REFDIV_W      10
`define PLR_REFDIV_RESET  10'h000
`define PLR_REFDIV_BAD    10'h002
`define PLR_REFDIV_ONE    10'h001
`define PLR_RESP_OKAY     2'h0
`define PLR_RESP_SLVERR   2'h2

`endif

// ==== plr_ref_ratio.v ====
// Turns the reference divider settings into the applied divide ratio.
// Assumes value and enable come straight from the register file.
`timescale 1ns/1ns
`include "plr_defs.vh"

module plr_ref_ratio #(
    parameter W = `PLR_REFDIV_W
) (
    // Clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // Settings
    input  wire         enable,
    input  wire [W-1:0] value,
    // Applied ratio
    output reg  [W-1:0] ratio,
    output reg          unsupported
);

    wire [W-1:0] one = `PLR_REFDIV_ONE;
    wire [W-1:0] bad = `PLR_REFDIV_BAD;

    // Bypass and codes 0 and 1 all pass the reference undivided
    always @(posedge aclk) begin
        if (!aresetn) begin
            ratio       <= `PLR_REFDIV_ONE;
            unsupported <= 1'b0;
        end else if (!enable) begin
            ratio       <= one;
            unsupported <= 1'b0;
        end else begin
            ratio       <= (value <= one) ? one : value;
            unsupported <= (value == bad);
        end
    end

endmodule

// ==== plr_regs.v ====
// Synthesizer pump bias and enable register bank with AXI4-Lite access.
// Assumes one clock, synchronous active-low reset, and a master that keeps
// at most one write and one read under way.
`timescale 1ns/1ns
`include "plr_defs.vh"

module plr_regs (
    // Clock and reset
    input  wire                   aclk,
    input  wire                   aresetn,
    // Write address channel
    input  wire [`PLR_ADDR_W-1:0] s_axi_awaddr,
    input  wire [2:0]             s_axi_awprot,
    input  wire                   s_axi_awvalid,
    output wire                   s_axi_awready,
    // Write data channel
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output wire                   s_axi_wready,
    // Write response channel
    output reg  [1:0]             s_axi_bresp,
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    // Read address channel
    input  wire [`PLR_ADDR_W-1:0] s_axi_araddr,
    input  wire [2:0]             s_axi_arprot,
    input  wire                   s_axi_arvalid,
    output reg                    s_axi_arready,
    // Read data channel
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready,
    // Charge pump controls
    output reg  [3:0]             pump_current_code,
    output reg                    pump_bias_source,
    output reg  [2:0]             pump_factory_reserved_bits,
    // Synthesizer enables
    output reg                    synth_enable,
    output reg                    ref_divider_enable,
    output reg  [4:0]             enable_factory_reserved_bits,
    // Reference divider
    output wire [9:0]             ref_div_ratio,
    output wire                   ref_div_unsupported
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    reg  [7:0]                  pll_pump_bias_ctrl;
    reg  [7:0]                  pll_enable_ctrl;
    reg  [`PLR_REFDIV_W-1:0]    ref_divider_value;

    wire [`PLR_ADDR_W-1:0]      held_addr;
    wire [31:0]                 held_data;
    wire [3:0]                  held_strb;
    wire                        both_held;
    wire                        wr_fire;
    wire [9:0]                  wr_idx;
    wire [9:0]                  rd_idx;
    reg  [31:0]                 next_rdata;
    reg  [1:0]                  next_rresp;

    // ------------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------------
    plr_axil_wr u_wr (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .awaddr    (s_axi_awaddr),
        .awvalid   (s_axi_awvalid),
        .awready   (s_axi_awready),
        .wdata     (s_axi_wdata),
        .wstrb     (s_axi_wstrb),
        .wvalid    (s_axi_wvalid),
        .wready    (s_axi_wready),
        .take      (wr_fire),
        .held_addr (held_addr),
        .held_data (held_data),
        .held_strb (held_strb),
        .both_held (both_held)
    );

    // Commit only once the previous response has been taken
    assign wr_fire = both_held & ~s_axi_bvalid;
    assign wr_idx  = held_addr[`PLR_ADDR_W-1:2];
    assign rd_idx  = s_axi_araddr[`PLR_ADDR_W-1:2];

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------

    // Reserved fields are stored as written; keeping them is software's job
    always @(posedge aclk) begin
        if (!aresetn) begin
            pll_pump_bias_ctrl <= `PLR_PUMP_RESET;
            pll_enable_ctrl    <= `PLR_ENABLE_RESET;
            ref_divider_value  <= `PLR_REFDIV_RESET;
        end else if (wr_fire) begin
            if (wr_idx == `PLR_IDX_PUMP) begin
                if (held_strb[0]) begin
                    pll_pump_bias_ctrl <= held_data[7:0];
                end
            end else if (wr_idx == `PLR_IDX_ENABLE) begin
                if (held_strb[0]) begin
                    // Unused top bit is masked off and never stored
                    pll_enable_ctrl <= held_data[7:0]
                                       & `PLR_EN_WMASK;
                end
            end else if (wr_idx == `PLR_IDX_REFDIV) begin
                if (held_strb[0]) begin
                    ref_divider_value[7:0] <= held_data[7:0];
                end
                if (held_strb[1]) begin
                    ref_divider_value[9:8] <= held_data[9:8];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------

    // Unmapped or read-only targets answer with a slave error
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PLR_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (wr_idx == `PLR_IDX_PUMP) begin
                s_axi_bresp <= `PLR_RESP_OKAY;
            end else if (wr_idx == `PLR_IDX_ENABLE) begin
                s_axi_bresp <= `PLR_RESP_OKAY;
            end else if (wr_idx == `PLR_IDX_REFDIV) begin
                s_axi_bresp <= `PLR_RESP_OKAY;
            end else begin
                s_axi_bresp <= `PLR_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------

    // Narrow registers sit in the low bits, upper bits read as zero
    always @* begin
        next_rdata = 32'h00000000;
        next_rresp = `PLR_RESP_OKAY;
        if (rd_idx == `PLR_IDX_PUMP) begin
            next_rdata[7:0] = pll_pump_bias_ctrl;
        end else if (rd_idx == `PLR_IDX_ENABLE) begin
            next_rdata[7:0] = pll_enable_ctrl
                              & `PLR_EN_WMASK;
        end else if (rd_idx == `PLR_IDX_REFDIV) begin
            next_rdata[9:0] = ref_divider_value;
        end else if (rd_idx == `PLR_IDX_STATUS) begin
            // Applied ratio and its flag show what the synthesizer sees
            next_rdata[9:0] = ref_div_ratio;
            next_rdata[10]  = ref_div_unsupported;
            next_rdata[11]  = synth_enable;
        end else begin
            next_rresp = `PLR_RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------

    // One read at a time; arready stays low until rdata is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `PLR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Synthesizer controls
    // ------------------------------------------------------------------

    // Outputs follow the stored fields one cycle after the commit edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            pump_current_code            <= 4'h2;
            pump_bias_source             <= 1'b1;
            pump_factory_reserved_bits   <= 3'h0;
            synth_enable                 <= 1'b0;
            ref_divider_enable           <= 1'b0;
            enable_factory_reserved_bits <= 5'h11;
        end else begin
            pump_current_code <= pll_pump_bias_ctrl[
                `PLR_PUMP_CODE_MSB:`PLR_PUMP_CODE_LSB];
            pump_bias_source  <= pll_pump_bias_ctrl[
                `PLR_PUMP_SRC_BIT];
            pump_factory_reserved_bits <= pll_pump_bias_ctrl[
                `PLR_PUMP_FCB_MSB:`PLR_PUMP_FCB_LSB];
            synth_enable      <= pll_enable_ctrl[
                `PLR_EN_SYNTH_BIT];
            ref_divider_enable <= pll_enable_ctrl[
                `PLR_EN_REFDIV_BIT];
            enable_factory_reserved_bits <= {
                pll_enable_ctrl[`PLR_EN_FCB43_MSB:`PLR_EN_FCB43_LSB],
                pll_enable_ctrl[`PLR_EN_FCB21_MSB:`PLR_EN_FCB21_LSB],
                pll_enable_ctrl[`PLR_EN_FCB0_BIT]};
        end
    end

    // ------------------------------------------------------------------
    // Reference divide ratio
    // ------------------------------------------------------------------

    // Ratio is registered inside, so it also lands one cycle after commit
    plr_ref_ratio #(
        .W (`PLR_REFDIV_W)
    ) u_ratio (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .enable      (pll_enable_ctrl[`PLR_EN_REFDIV_BIT]),
        .value       (ref_divider_value),
        .ratio       (ref_div_ratio),
        .unsupported (ref_div_unsupported)
    );

endmodule

// ==== plr_regs_chk.sv ====
// Port checks for the synthesizer pump and enable register bank.
// Assumes it is bound to plr_regs and that one clock drives it all.
`timescale 1ns/1ns
`include "plr_defs.vh"

module plr_regs_chk (
    // Clock and reset
    input wire                   aclk,
    input wire                   aresetn,
    // Register bus
    input wire [`PLR_ADDR_W-1:0] s_axi_araddr,
    input wire                   s_axi_arvalid,
    input wire                   s_axi_arready,
    input wire                   s_axi_awvalid,
    input wire                   s_axi_awready,
    input wire                   s_axi_wvalid,
    input wire                   s_axi_wready,
    input wire [1:0]             s_axi_bresp,
    input wire                   s_axi_bvalid,
    input wire                   s_axi_bready,
    input wire [31:0]            s_axi_rdata,
    input wire                   s_axi_rvalid,
    input wire                   s_axi_rready,
    // Synthesizer controls
    input wire [3:0]             pump_current_code,
    input wire                   pump_bias_source,
    input wire [2:0]             pump_factory_reserved_bits,
    input wire                   synth_enable,
    input wire                   ref_divider_enable,
    input wire [4:0]             enable_factory_reserved_bits,
    input wire [9:0]             ref_div_ratio,
    input wire                   ref_div_unsupported
);
    // ------
    // Helpers
    // ------
    reg  [`PLR_ADDR_W-1:0] rd_addr;
    wire [4:0]             efr = enable_factory_reserved_bits;
    wire [7:0]             pump_vec = {pump_factory_reserved_bits,
                                       pump_bias_source, pump_current_code};
    wire [7:0]             en_vec = {1'b0, efr[4:3], ref_divider_enable,
                                     efr[2:1], synth_enable, efr[0]};

    // Address of the read in flight, to know what rdata should mirror
    always @(posedge aclk) begin
        if (!aresetn)
            rd_addr <= {`PLR_ADDR_W{1'b0}};
        else if (s_axi_arvalid && s_axi_arready)
            rd_addr <= s_axi_araddr;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------
    // Assertions
    // ------
    property p_reset_vals;
        $rose(aresetn) |-> pump_current_code == 4'h2 && pump_bias_source
            && !synth_enable && !ref_divider_enable;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("controls not at reset values");
    // Controls may move only the cycle after a write response appears
    property p_ctrl_lag;
        aresetn && $past(aresetn) && $changed({pump_vec, en_vec})
            |-> $past(s_axi_bvalid)
            && !$past(s_axi_bvalid, 2);
    endproperty
    a_ctrl_lag: assert property (p_ctrl_lag)
        else $error("controls changed outside write commit");
    // Readback compared only when no write landed lately (outputs lag)
    property p_pump_read;
        $rose(s_axi_rvalid) && rd_addr == 12'h160 && s_axi_awready
            && $past(s_axi_awready) && $past(s_axi_awready, 2)
            |-> s_axi_rdata == {24'h0, pump_vec};
    endproperty
    a_pump_read: assert property (p_pump_read)
        else $error("pump readback differs from controls");
    property p_en_read;
        $rose(s_axi_rvalid) && rd_addr == 12'h164 && s_axi_awready
            && $past(s_axi_awready) && $past(s_axi_awready, 2)
            |-> s_axi_rdata == {24'h0, en_vec};
    endproperty
    a_en_read: assert property (p_en_read)
        else $error("enable readback differs from controls");
    property p_bypass;
        !ref_divider_enable && !$past(ref_divider_enable)
            |-> ref_div_ratio == 10'h001 && !ref_div_unsupported;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("divider not bypassed while disabled");
    property p_unsup;
        (ref_div_ratio == 10'h002) == ref_div_unsupported;
    endproperty
    a_unsup: assert property (p_unsup)
        else $error("unsupported flag disagrees with ratio");
    property p_b_time;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_b_time: assert property (p_b_time)
        else $error("write response late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped before taken");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped before taken");
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the pump and enable register bank.
// Assumes plr_regs and plr_regs_chk are compiled before this file.
`timescale 1ns/1ns
`include "plr_defs.vh"
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("unexpected at %0t: value mismatch", $time); \
    end \
end

module tb_top;
    // ------
    // Signals, all inputs given values at time zero
    // ------
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [1:0]  br;
        logic [31:0] q;
        logic [1:0]  rr;
    } plr_row_t;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb = 4'h0, pump_current_code;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, br, rr;
    logic        pump_bias_source, synth_enable, ref_divider_enable;
    logic [2:0]  pump_factory_reserved_bits;
    logic [4:0]  enable_factory_reserved_bits;
    logic [9:0]  ref_div_ratio;
    logic        ref_div_unsupported;
    logic [11:0] e;
    int          err_total = 0, comparisons = 0, cycles = 0;
    wire  [4:0]  efr = enable_factory_reserved_bits;
    wire  [7:0]  pump_vec = {pump_factory_reserved_bits, pump_bias_source,
                             pump_current_code};
    wire  [7:0]  en_vec = {1'b0, efr[4:3], ref_divider_enable, efr[2:1],
                           synth_enable, efr[0]};
    // Ordinary writes with the readback and responses they should give
    // Every write keeps reserved fields at reset value
    // Pump codes span low to high as software would pick them
    plr_row_t    rows [7] = '{
        '{12'h160, 32'h00, 4'hF, `PLR_RESP_OKAY, 32'h00, `PLR_RESP_OKAY},
        '{12'h160, 32'h1F, 4'hF, `PLR_RESP_OKAY, 32'h1F, `PLR_RESP_OKAY},
        '{12'h160, 32'h05, 4'h0, `PLR_RESP_OKAY, 32'h1F, `PLR_RESP_OKAY},
        '{12'h164, 32'hC3, 4'hF, `PLR_RESP_OKAY, 32'h43, `PLR_RESP_OKAY},
        '{12'h164, 32'h51, 4'hF, `PLR_RESP_OKAY, 32'h51, `PLR_RESP_OKAY},
        '{12'h180, '1, 4'hF, `PLR_RESP_OKAY, 32'h3FF, `PLR_RESP_OKAY},
        '{12'h168, 32'h01, 4'hF, `PLR_RESP_SLVERR, 32'h0, `PLR_RESP_SLVERR}};

    // Protection inputs tied: the block ignores them
    plr_regs dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pump_current_code, .pump_bias_source, .pump_factory_reserved_bits,
        .synth_enable, .ref_divider_enable, .enable_factory_reserved_bits,
        .ref_div_ratio, .ref_div_unsupported);

    // ------
    // Clock, bus tasks and closing
    // ------
    initial begin
        forever #2 aclk = ~aclk;
    end

    // Write with both halves offered together; bw delays bready
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input int bw,
                      output logic [1:0] r);
        logic ad = 1'b0;
        logic wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (bw == 0);
        while (!(ad && wd)) begin
            @(posedge aclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end
        repeat (bw) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read; rw delays rready so the answer has to stand
    task automatic rd(input logic [11:0] a, input int rw,
                      output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (rw == 0);
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat (rw) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task end_of_test;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    // ------
    // Main sequence
    // ------
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            wr(rows[i].a, rows[i].d, rows[i].s, 0, br);
            `CHK(br, rows[i].br)
            rd(rows[i].a, 0, q, rr);
            `CHK(q, rows[i].q)
            `CHK(rr, rows[i].rr)
            if (rows[i].a == 12'h160)
                `CHK(pump_vec, rows[i].q[7:0])
            if (rows[i].a == 12'h164)
                `CHK(en_vec, rows[i].q[7:0])
        end
        // Divider codes around the unsupported one, divider enabled
        for (int v = 0; v < 4; v++) begin
            wr(12'h180, 32'(v), 4'h3, 0, br);
            rd(12'h184, 0, q, rr);
            e = {1'b0, v == 2, (v < 2) ? 10'h001 : 10'(v)};
            `CHK(q, {20'h0, e})
            `CHK({ref_div_unsupported, ref_div_ratio}, e[10:0])
        end
        // Bypass divider, synthesizer on, with both answers stalled
        wr(12'h164, 32'h43, 4'h1, 3, br);
        rd(12'h184, 3, q, rr);
        `CHK(q, 32'h801)
        `CHK(synth_enable, 1'b1)
        // Status is read only: the write is refused
        wr(12'h184, 32'h0, 4'hF, 0, br);
        `CHK(br, `PLR_RESP_SLVERR)
        // Second reset in mid-run brings every field back
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(pump_vec, `PLR_PUMP_RESET)
        `CHK(en_vec, `PLR_ENABLE_RESET)
        rd(12'h160, 0, q, rr);
        `CHK(q, 32'(`PLR_PUMP_RESET))
        rd(12'h164, 0, q, rr);
        `CHK(q, 32'(`PLR_ENABLE_RESET))
        end_of_test();
    end
endmodule

bind plr_regs plr_regs_chk chk_u (
    .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .pump_current_code, .pump_bias_source,
    .pump_factory_reserved_bits, .synth_enable, .ref_divider_enable,
    .enable_factory_reserved_bits, .ref_div_ratio, .ref_div_unsupported);
